// *** hdl/asp_map.svh ***
/*
 * Constants of the serial host port: word size, bit counts, reset values,
 * buffer fill levels and the self-clocking timing.
 * Assumes inclusion by bare name from package and design files.
 */
`ifndef ASP_MAP_SVH
`define ASP_MAP_SVH

// converter control word and conversion word width
`define ASP_WORD_W 24
`define ASP_CTL_RST 24'h000000
`define ASP_WORD_RST 24'h000000

// bit counter: width, first bit, last bit index, full word
`define ASP_CNT_W 5
`define ASP_CNT_ZERO 5'h00
`define ASP_CNT_ONE 5'h01
`define ASP_CNT_LAST 5'h17
`define ASP_CNT_FULL 5'h18

// idle level of every synchronised host pin
`define ASP_PIN_IDLE 1'b1

// two-entry buffer fill levels
`define ASP_BUF_EMPTY 2'h0
`define ASP_BUF_ONE 2'h1
`define ASP_BUF_FULL 2'h2
`define ASP_BUF_STEP 2'h1

// self-clocking serial clock: half period in ns, clock period in ns
`define ASP_MCLK_NS 4
`define ASP_SCLK_HALF_NS 64
`define ASP_DIV_W 5
`define ASP_DIV_ZERO 5'h00
`define ASP_DIV_ONE 5'h01
`define ASP_SCLK_HALF_CYC (`ASP_SCLK_HALF_NS / `ASP_MCLK_NS)

`endif

// *** hdl/asp_pkg.sv ***
/*
 * Types of the serial host port: the word, the group of host pins and
 * the conversion word as it arrives from the filter.
 * Assumes asp_map.svh on the include path.
 */
`include "asp_map.svh"

package asp_pkg;

   typedef logic [`ASP_WORD_W-1:0] asp_word_t;

   // host pins in the order they are synchronised
   typedef struct packed {
      logic wfs_n;
      logic rfs_n;
      logic sel;
      logic sclk;
      logic sdi;
      logic selfclk;
   } asp_pins_t;

   // raw two's complement result and the input range it was taken in
   typedef struct packed {
      logic bipolar;
      asp_word_t raw;
   } asp_conv_t;

   // read frame kind
   typedef enum logic [2:0] {
      RD_IDLE = 3'h1,
      RD_CTL = 3'h2,
      RD_DATA = 3'h4
   } asp_rd_t;

endpackage : asp_pkg

// *** hdl/asp_buf.sv ***
/*
 * Two-entry buffer for conversion words with valid and ready on both
 * sides; the head word comes straight out of a register.
 * Assumes a single clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`include "asp_map.svh"

module asp_buf
   import asp_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // filling side
   input wire asp_word_t in_data,
   input wire logic in_valid,
   output logic in_ready,
   // draining side
   output asp_word_t out_data,
   output logic out_valid,
   input wire logic out_ready
);

   logic [1:0] cnt;
   asp_word_t tail;
   logic push;
   logic pop;

   assign in_ready = (cnt != `ASP_BUF_FULL);
   assign out_valid = (cnt != `ASP_BUF_EMPTY);
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_ff @(posedge mclk) begin
      if (rst) begin
         cnt <= `ASP_BUF_EMPTY;
      end else if (push && !pop) begin
         cnt <= cnt + `ASP_BUF_STEP;
      end else if (pop && !push) begin
         cnt <= cnt - `ASP_BUF_STEP;
      end
   end

   // head always holds the oldest word
   always_ff @(posedge mclk) begin
      if (rst) begin
         out_data <= `ASP_WORD_RST;
      end else if (push && (cnt == `ASP_BUF_EMPTY ||
                            (cnt == `ASP_BUF_ONE && pop))) begin
         out_data <= in_data;
      end else if (pop && cnt == `ASP_BUF_FULL) begin
         out_data <= tail;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         tail <= `ASP_WORD_RST;
      end else if (push && cnt == `ASP_BUF_ONE && !pop) begin
         tail <= in_data;
      end
   end

endmodule : asp_buf

// *** hdl/asp_port.sv ***
/*
 * Frame-synchronised bidirectional serial host port of a measurement
 * converter: control word write and read, conversion word read, ready
 * flag, self or external serial clock.
 * Assumes host pins asynchronous to mclk (synchronised here) and the
 * converter side on mclk. Serial clock below mclk/8 in external mode.
 */
// Operation
// - write accepted only after write sync falls
// - self clock starts after write sync falls
// - self mode: read sync starts clock, data
// - external mode: data driven after read sync
// - ready falls when new word available
// - ready rises after full word shifted out
// - ready also reports finished calibration
// - data read drives only when ready low
// - write bits sampled on rising clock edges
// - unipolar natural binary, bipolar offset binary
// - select low: control word write/read
// - control word loads only on 24 bits
// - pulses beyond the 24th are ignored
// - select high read returns conversion word
`timescale 1ns/1ps
`include "asp_map.svh"

module asp_port
   import asp_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst,
   // host frame and select pins
   input wire logic write_frame_sync_n,
   input wire logic read_frame_sync_n,
   input wire logic register_select,
   input wire logic self_clock_mode,
   // serial clock pin
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe_n,
   // serial data pin
   input wire logic serial_io_in,
   output logic serial_io_out,
   output logic serial_io_oe_n,
   // ready pin
   output logic result_ready_n,
   // converter side
   input wire asp_conv_t conv_in,
   input wire logic conv_valid,
   output logic conv_ready,
   input wire logic cal_done,
   output asp_word_t converter_control_word
);

   asp_pins_t pin_raw;
   asp_pins_t pin_s1;
   asp_pins_t pin_s;
   asp_pins_t pin_q;
   logic wfs_fall;
   logic wfs_rise;
   logic rfs_fall;
   logic ext_rise;
   logic ext_fall;
   logic gen_rise;
   logic gen_fall;
   logic sclk_rise;
   logic sclk_fall;
   logic clk_run;
   logic sclk_gen;
   logic [`ASP_DIV_W-1:0] div;
   logic wr_act;
   logic wr_sel;
   logic [`ASP_CNT_W-1:0] wr_cnt;
   asp_word_t wr_sh;
   asp_rd_t rd_st;
   logic [`ASP_CNT_W-1:0] rd_cnt;
   asp_word_t rd_sh;
   logic rd_done;
   logic cal_flag;
   logic next_ready_n;
   asp_word_t coded;
   asp_word_t buf_head;
   logic buf_vld;

   // -------- pin synchronisers --------
   assign pin_raw = {write_frame_sync_n, read_frame_sync_n, register_select,
                     sclk_in, serial_io_in, self_clock_mode};

   genvar gi;
   generate
      for (gi = 0; gi < $bits(asp_pins_t); gi++) begin : g_sync
         always_ff @(posedge mclk) begin
            if (rst) begin
               pin_s1[gi] <= `ASP_PIN_IDLE;
               pin_s[gi] <= `ASP_PIN_IDLE;
               pin_q[gi] <= `ASP_PIN_IDLE;
            end else begin
               pin_s1[gi] <= pin_raw[gi];
               pin_s[gi] <= pin_s1[gi];
               pin_q[gi] <= pin_s[gi];
            end
         end
      end
   endgenerate

   assign wfs_fall = pin_q.wfs_n & ~pin_s.wfs_n;
   assign wfs_rise = ~pin_q.wfs_n & pin_s.wfs_n;
   assign rfs_fall = pin_q.rfs_n & ~pin_s.rfs_n;
   assign ext_rise = ~pin_q.sclk & pin_s.sclk;
   assign ext_fall = pin_q.sclk & ~pin_s.sclk;

   // -------- serial clock --------
   // self clock runs only inside an open frame that still needs bits
   assign clk_run = pin_s.selfclk &
                    ((wr_act && wr_cnt < `ASP_CNT_FULL) ||
                     (rd_st != RD_IDLE && rd_cnt < `ASP_CNT_FULL));

   always_ff @(posedge mclk) begin
      if (rst || !clk_run) begin
         div <= `ASP_DIV_ZERO;
         sclk_gen <= `ASP_PIN_IDLE;
      end else if (div == `ASP_DIV_W'(`ASP_SCLK_HALF_CYC - 1)) begin
         div <= `ASP_DIV_ZERO;
         sclk_gen <= ~sclk_gen;
      end else begin
         div <= div + `ASP_DIV_ONE;
      end
   end

   assign gen_rise = clk_run && !sclk_gen &&
                     div == `ASP_DIV_W'(`ASP_SCLK_HALF_CYC - 1);
   assign gen_fall = clk_run && sclk_gen &&
                     div == `ASP_DIV_W'(`ASP_SCLK_HALF_CYC - 1);
   assign sclk_rise = pin_s.selfclk ? gen_rise : ext_rise;
   assign sclk_fall = pin_s.selfclk ? gen_fall : ext_fall;
   assign sclk_out = sclk_gen;
   assign sclk_oe_n = ~clk_run;

   // -------- write frame --------
   always_ff @(posedge mclk) begin
      if (rst) begin
         wr_act <= 1'b0;
         wr_sel <= 1'b0;
      end else if (wfs_fall) begin
         wr_act <= 1'b1;
         wr_sel <= pin_s.sel;
      end else if (wfs_rise) begin
         wr_act <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || wfs_fall) begin
         wr_cnt <= `ASP_CNT_ZERO;
         wr_sh <= `ASP_WORD_RST;
      end else if (wr_act && !pin_s.wfs_n && sclk_rise &&
                   wr_cnt < `ASP_CNT_FULL) begin
         wr_sh <= {wr_sh[`ASP_WORD_W-2:0], pin_s.sdi};
         wr_cnt <= wr_cnt + `ASP_CNT_ONE;
      end
   end

   // control word loads only from a complete frame with select low
   always_ff @(posedge mclk) begin
      if (rst) begin
         converter_control_word <= `ASP_CTL_RST;
      end else if (wfs_rise && wr_act && !wr_sel &&
                   wr_cnt == `ASP_CNT_FULL) begin
         converter_control_word <= wr_sh;
      end
   end

   // -------- conversion words --------
   always_comb begin
      coded = conv_in.raw;
      if (conv_in.bipolar) begin
         coded[`ASP_WORD_W-1] = ~conv_in.raw[`ASP_WORD_W-1];
      end
   end

   asp_buf u_buf (
      .mclk(mclk),
      .rst(rst),
      .in_data(coded),
      .in_valid(conv_valid),
      .in_ready(conv_ready),
      .out_data(buf_head),
      .out_valid(buf_vld),
      .out_ready(rd_done)
   );

   // -------- read frame --------
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_st <= RD_IDLE;
      end else begin
         unique case (rd_st)
            RD_IDLE: begin
               if (rfs_fall && !pin_s.sel) begin
                  rd_st <= RD_CTL;
               end else if (rfs_fall && !result_ready_n) begin
                  rd_st <= RD_DATA;
               end
            end
            RD_CTL, RD_DATA: begin
               if (pin_s.rfs_n) begin
                  rd_st <= RD_IDLE;
               end
            end
         endcase
      end
   end

   // first bit stands from the frame start, later bits move on falls
   always_ff @(posedge mclk) begin
      if (rst) begin
         rd_cnt <= `ASP_CNT_ZERO;
         rd_sh <= `ASP_WORD_RST;
      end else if (rd_st == RD_IDLE) begin
         rd_cnt <= `ASP_CNT_ZERO;
         if (rfs_fall) begin
            rd_sh <= pin_s.sel ? buf_head : converter_control_word;
         end
      end else if (sclk_rise && rd_cnt < `ASP_CNT_FULL) begin
         rd_cnt <= rd_cnt + `ASP_CNT_ONE;
      end else if (sclk_fall && rd_cnt != `ASP_CNT_ZERO &&
                   rd_cnt < `ASP_CNT_FULL) begin
         rd_sh <= {rd_sh[`ASP_WORD_W-2:0], 1'b0};
      end
   end

   assign rd_done = (rd_st == RD_DATA) && sclk_rise &&
                    rd_cnt == `ASP_CNT_LAST;
   assign serial_io_out = rd_sh[`ASP_WORD_W-1];
   assign serial_io_oe_n = (rd_st == RD_IDLE);

   // -------- ready flag --------
   always_ff @(posedge mclk) begin
      if (rst) begin
         cal_flag <= 1'b0;
      end else if (cal_done) begin
         cal_flag <= 1'b1;
      end else if (rd_done) begin
         cal_flag <= 1'b0;
      end
   end

   // a finished word forces one high cycle so the next word falls again
   always_comb begin
      next_ready_n = ~(buf_vld | cal_flag);
      if (rd_done) begin
         next_ready_n = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         result_ready_n <= 1'b1;
      end else begin
         result_ready_n <= next_ready_n;
      end
   end

   // -------- checks --------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   a_ctl_load_cause: assert property (
      converter_control_word != $past(converter_control_word) |->
      $past(wfs_rise && wr_act && wr_cnt == `ASP_CNT_FULL))
      else $error("control word changed outside a complete write");

   a_short_write_kept: assert property (
      wfs_rise && wr_cnt != `ASP_CNT_FULL |=>
      $stable(converter_control_word))
      else $error("short write changed the control word");

   a_wr_count_cap: assert property (
      wr_act && wr_cnt == `ASP_CNT_FULL && !wfs_fall |=>
      wr_cnt == `ASP_CNT_FULL && $stable(wr_sh))
      else $error("pulse beyond the last bit was taken");

   a_wr_sample_rise: assert property (
      wr_act && !pin_s.wfs_n && sclk_rise && wr_cnt < `ASP_CNT_FULL |=>
      wr_sh[0] == $past(pin_s.sdi) &&
      wr_cnt == $past(wr_cnt) + `ASP_CNT_ONE)
      else $error("write bit not sampled on rising clock");

   a_sclk_in_frame: assert property (
      !sclk_oe_n |-> pin_s.selfclk && (wr_act || rd_st != RD_IDLE))
      else $error("serial clock driven outside a frame");

   a_sclk_read_start: assert property (
      pin_s.selfclk && rfs_fall && !pin_s.sel |=>
      !sclk_oe_n && !serial_io_oe_n)
      else $error("self clock read did not start clock and data");

   a_sdo_in_frame: assert property (
      !serial_io_oe_n |-> !$past(pin_s.rfs_n))
      else $error("data line driven without read frame");

   a_data_needs_ready: assert property (
      rd_st == RD_IDLE && rfs_fall && pin_s.sel && result_ready_n |=>
      serial_io_oe_n)
      else $error("data read driven while ready high");

   a_data_read_word: assert property (
      rd_st == RD_IDLE && rfs_fall && pin_s.sel && !result_ready_n |=>
      rd_sh == $past(buf_head) && !serial_io_oe_n)
      else $error("data read did not load conversion word");

   a_ctl_read_word: assert property (
      rd_st == RD_IDLE && rfs_fall && !pin_s.sel |=>
      rd_sh == $past(converter_control_word))
      else $error("control read did not load control word");

   a_ready_fall_new: assert property (
      $rose(buf_vld) |=> !result_ready_n)
      else $error("ready did not fall for new word");

   a_ready_rise_done: assert property (
      rd_done && !cal_done |=> result_ready_n ##1
      (result_ready_n == !$past(buf_vld)))
      else $error("ready did not rise after full word");

   a_ready_cal: assert property (
      cal_done ##1 !rd_done |=> !result_ready_n)
      else $error("ready did not report calibration");

   a_offset_binary: assert property (
      1'b1 |-> coded[`ASP_WORD_W-1] ==
      (conv_in.raw[`ASP_WORD_W-1] ^ conv_in.bipolar))
      else $error("conversion word coding wrong");

   c_ctl_write: cover property (
      wfs_rise && wr_act && !wr_sel && wr_cnt == `ASP_CNT_FULL);
   c_short_write: cover property (
      wfs_rise && wr_act && wr_cnt != `ASP_CNT_FULL);
   c_data_read: cover property (rd_done);
   c_self_read: cover property (rd_done && pin_s.selfclk);
   c_cal_ready: cover property (cal_done ##[1:4] !result_ready_n);

endmodule : asp_port

// *** tb/asp_host.sv ***
/*
 * Host model: frame syncs, select, external serial clock, data pin.
 * Assumes the port's split pins are joined here into wire levels.
 */
`timescale 1ns/1ps

module asp_host
   import asp_pkg::*;
(
   // clock
   input wire logic mclk,
   // device pins
   input wire logic sclk_out,
   input wire logic sclk_oe_n,
   input wire logic serial_io_out,
   input wire logic serial_io_oe_n,
   // host pins as wire levels
   output logic wfs_n,
   output logic rfs_n,
   output logic sel,
   output logic sclk_in,
   output logic sclk_w,
   output logic serial_io_line
);
   logic sdi_q;
   logic drive;
   logic junk = 1'b0;
   initial begin
      wfs_n = 1'b1;
      rfs_n = 1'b1;
      sel = 1'b0;
      sclk_in = 1'b1;
      sdi_q = 1'b0;
      drive = 1'b0;
   end
   // a released data line never holds its last level
   always @(posedge mclk) junk <= ~junk;
   assign sclk_w = sclk_oe_n ? sclk_in : sclk_out;
   assign serial_io_line = !serial_io_oe_n ? serial_io_out : drive ? sdi_q : junk;

   task automatic frame(input logic wr, input logic ext, input logic s,
      input int n, input asp_word_t wd, output asp_word_t rd,
      output int rises, output int drv);
      int i;
      logic prev;
      asp_word_t w;
      rd = '0;
      rises = 0;
      drv = 0;
      w = wd;
      @(posedge mclk);
      sel <= s;
      drive <= wr;
      if (wr) wfs_n <= 1'b0;
      else rfs_n <= 1'b0;
      if (ext) begin
         // quarter-ns offset keeps every host clock edge off an mclk edge
         #100.25;
         for (i = 0; i < n; i++) begin
            sclk_in <= 1'b0;
            sdi_q <= w[23];
            #62.5;
            rd = {rd[22:0], serial_io_line};
            drv += !serial_io_oe_n;
            sclk_in <= 1'b1;
            w = w << 1;
            rises++;
            #62.5;
         end
      end else begin
         prev = 1'b1;
         for (i = 0; i < 3000 && rises < n; i++) begin
            @(posedge mclk);
            if (sclk_w && !prev) begin
               rd = {rd[22:0], serial_io_line};
               drv += !serial_io_oe_n;
               w = w << 1;
               rises++;
            end
            if (!sclk_w && prev) sdi_q <= w[23];
            prev = sclk_w;
         end
      end
      // full 24-bit reads of the control word are asked for by the bench
      repeat (8) @(posedge mclk);
      wfs_n <= 1'b1;
      rfs_n <= 1'b1;
      drive <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask : frame
endmodule : asp_host

// *** tb/asp_port_tb_top.sv ***
/*
 * Bench for the serial host port: control word and conversion word
 * frames in both clocking modes, buffer fill, ready flag.
 * Assumes asp_host as the far side and asp_pkg constants.
 */
`timescale 1ns/1ps

module asp_port_tb_top;
   import asp_pkg::*;
   logic mclk, rst, self_mode, conv_valid, conv_ready, cal_done;
   logic wfs_n, rfs_n, sel, sclk_in, sclk_w, serial_io_line;
   logic sclk_out, sclk_oe_n, sdo, sdo_oe_n, ready_n;
   asp_conv_t conv_in;
   asp_word_t ctl, rd;
   int failures = 0;
   int comparisons = 0;
   int k;

   asp_host host (.mclk(mclk), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
      .serial_io_out(sdo), .serial_io_oe_n(sdo_oe_n), .wfs_n(wfs_n),
      .rfs_n(rfs_n), .sel(sel), .sclk_in(sclk_in), .sclk_w(sclk_w),
      .serial_io_line(serial_io_line));
   asp_port dut (.mclk(mclk), .rst(rst), .write_frame_sync_n(wfs_n),
      .read_frame_sync_n(rfs_n), .register_select(sel),
      .self_clock_mode(self_mode), .sclk_in(sclk_w), .sclk_out(sclk_out),
      .sclk_oe_n(sclk_oe_n), .serial_io_in(serial_io_line), .serial_io_out(sdo),
      .serial_io_oe_n(sdo_oe_n), .result_ready_n(ready_n),
      .conv_in(conv_in), .conv_valid(conv_valid), .conv_ready(conv_ready),
      .cal_done(cal_done), .converter_control_word(ctl));

   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic check(input asp_word_t seen, input asp_word_t exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic xfer(input logic wr, input logic ext, input logic s,
      input int n, input asp_word_t wd, input int exp_drv);
      int r, d;
      @(posedge mclk);
      self_mode <= !ext;
      repeat (6) @(posedge mclk);
      host.frame(wr, ext, s, n, wd, rd, r, d);
      if (r != n) begin
         check(24'(r), 24'(n));
         complete_run();
      end else begin
         check(24'(d), 24'(exp_drv));
         check(24'(sdo_oe_n), 24'h000001);
         check(24'(sclk_oe_n), 24'h000001);
      end
   endtask : xfer

   task automatic push(input logic bip, input asp_word_t raw);
      check(24'(conv_ready), 24'h000001);
      @(posedge mclk);
      conv_in <= '{bipolar: bip, raw: raw};
      conv_valid <= 1'b1;
      @(posedge mclk);
      conv_valid <= 1'b0;
   endtask : push

   task automatic ready_low;
      for (k = 0; k < 20 && ready_n !== 1'b0; k++) @(posedge mclk);
      check(24'(ready_n), 24'h000000);
      if (ready_n !== 1'b0) complete_run();
   endtask : ready_low

   initial begin
      rst = 1'b1;
      self_mode = 1'b0;
      conv_valid = 1'b0;
      cal_done = 1'b0;
      conv_in = '0;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      check(ctl, 24'h000000);
      check(24'(ready_n), 24'h000001);
      check(24'(sdo_oe_n), 24'h000001);
      xfer(1'b1, 1'b1, 1'b0, 24, 24'ha5c3f0, 0);
      check(ctl, 24'ha5c3f0);
      xfer(1'b0, 1'b1, 1'b0, 24, 24'h000000, 24);
      check(rd, 24'ha5c3f0);
      xfer(1'b1, 1'b1, 1'b0, 12, 24'h123456, 0);
      check(ctl, 24'ha5c3f0);
      xfer(1'b1, 1'b1, 1'b0, 30, 24'h5a0f96, 0);
      check(ctl, 24'h5a0f96);
      xfer(1'b1, 1'b1, 1'b1, 24, 24'h111111, 0);
      check(ctl, 24'h5a0f96);
      xfer(1'b1, 1'b0, 1'b0, 24, 24'h3c6e18, 0);
      check(ctl, 24'h3c6e18);
      xfer(1'b0, 1'b0, 1'b0, 24, 24'h000000, 24);
      check(rd, 24'h3c6e18);
      xfer(1'b0, 1'b1, 1'b1, 24, 24'h000000, 0);
      push(1'b0, 24'h923456);
      ready_low();
      push(1'b1, 24'h000001);
      @(posedge mclk);
      check(24'(conv_ready), 24'h000000);
      xfer(1'b0, 1'b0, 1'b1, 24, 24'h000000, 24);
      check(rd, 24'h923456);
      ready_low();
      xfer(1'b0, 1'b1, 1'b1, 24, 24'h000000, 24);
      check(rd, 24'h800001);
      check(24'(ready_n), 24'h000001);
      @(posedge mclk);
      cal_done <= 1'b1;
      @(posedge mclk);
      cal_done <= 1'b0;
      ready_low();
      xfer(1'b0, 1'b1, 1'b1, 24, 24'h000000, 24);
      check(24'(ready_n), 24'h000001);
      complete_run();
   end
endmodule : asp_port_tb_top
